// >>> sc_port_defs.svh
// constants for the smart card serial control port, both ends
// Behaviour
// - falling load strobe copies shift word to command
// - new command acts at once on load
// - rising load strobe captures status into shifter
// - host keeps load strobe low while awaiting status
// - host masters link, clock idles high
// - serial out feeds next device serial in
// - host shifts one byte per chained device
// - host loads only after all bytes shifted
// - strobe low: serial out shows card present
// - fault starts deactivation within about 30 us
// - logic supply at ground forces shutdown
// - power bits both zero run deactivation
// - fault pin low equals fault status bit
// - card present after 32 ms debounce
`ifndef SC_PORT_DEFS_SVH
`define SC_PORT_DEFS_SVH
`define CLK_HZ             25000000
`define CLK_PER_US         (`CLK_HZ / 1000000)
`define DEBOUNCE_MS        32
`define DEBOUNCE_CYCLES    (`DEBOUNCE_MS * 1000 * `CLK_PER_US)
`define FAULT_DELAY_US     30
`define FAULT_DELAY_CYCLES (`FAULT_DELAY_US * `CLK_PER_US)
`define DEACT_US           5
`define DEACT_CYCLES       (`DEACT_US * `CLK_PER_US)
`define FRAME_BITS         8
`define CARD_PRESENT_POS   7
`define ACTIVE_POS         6
`define FAULT_POS          4
`define PWR_BIT1_POS       1
`define PWR_BIT0_POS       0
`define CMD_RESET          8'h00
`define REG_CTRL           12'h000
`define REG_TXDATA         12'h004
`define REG_RXDATA         12'h008
`define REG_STATUS         12'h00C
`define CTRL_START_POS     0
`define STAT_BUSY_POS      0
`define STAT_FAULT_POS     1
`define STAT_CARD_POS      2
`define SCLK_HALF          2
`define LD_SETUP           4
`define CHAIN_BYTES        1
`endif

// >>> sc_port_pkg.sv
// types shared by both ends of the serial control port
package sc_port_pkg;
  typedef enum logic [2:0] {
    DEV_OFF   = 3'b001,
    DEV_ON    = 3'b010,
    DEV_DEACT = 3'b100
  } dev_state_t;

  typedef enum logic [2:0] {
    H_IDLE  = 3'b001,
    H_SETUP = 3'b010,
    H_SHIFT = 3'b100
  } host_state_t;

  typedef struct packed {
    logic       ld_s1;
    logic       ld_s2;
    logic       ld_d;
    logic       det_s1;
    logic       det_s2;
    logic       uv_s1;
    logic       uv_s2;
    logic       sup_s1;
    logic       sup_s2;
    logic [7:0] cmd;
    logic [7:0] snap;
    logic       snap_tgl;
    logic       present;
    logic       fault;
    logic [19:0] deb_cnt;
    logic [9:0] flt_cnt;
    logic       flt_pend;
    logic [7:0] seq_cnt;
    dev_state_t state;
  } dev_core_t;

  typedef struct packed {
    logic [7:0] shreg;
    logic       used_tgl;
  } dev_shift_t;

  typedef struct packed {
    logic       out_bit;
    logic       seen_tgl;
  } dev_out_t;

  typedef struct packed {
    host_state_t st;
    logic [7:0]  cnt;
    logic [5:0]  bits;
    logic        sclk;
    logic        din;
    logic        ld_n;
    logic [31:0] txreg;
    logic [31:0] sh;
    logic [31:0] rx;
    logic        dout_s1;
    logic        dout_s2;
    logic        flt_s1;
    logic        flt_s2;
    logic [31:0] prdata;
    logic        pslverr;
  } host_t;
endpackage

// >>> sc_link_if.sv
// four-wire serial link plus open-drain fault line
`timescale 1ns/100ps
interface sc_link_if;
  logic sclk;
  logic din;
  logic dout;
  logic load_strobe_n;
  logic fault_o;
  logic fault_oe_n;
  logic fault_line;

  // pulled up unless the device sinks it
  assign fault_line = fault_oe_n ? 1'b1 : fault_o;

  modport host (
    output sclk,
    output din,
    output load_strobe_n,
    input  dout,
    input  fault_line
  );

  modport dev (
    input  sclk,
    input  din,
    input  load_strobe_n,
    output dout,
    output fault_o,
    output fault_oe_n
  );
endinterface

// >>> sc_port_dev.sv
// device end: shift register on the link clock, command and status on clk
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "sc_port_defs.svh"
module sc_port_dev #(
  parameter int unsigned DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
  // system
  input  wire logic       clk,
  input  wire logic       nrst,
  // link
  sc_link_if.dev          link,
  // card side sense
  input  wire logic       card_detect_in,
  input  wire logic       supply_undervolt_sense,
  input  wire logic       logic_supply,
  // card side control
  output logic            card_vcc_en,
  output logic            card_rst_en,
  output logic [1:0]      vcc_sel,
  output logic [7:0]      command,
  output logic            shutdown,
  output logic            deact_busy
);
  localparam logic [19:0] DEB_LAST   = 20'(DEBOUNCE_CYCLES - 1);
  localparam logic [9:0]  FLT_LAST   = 10'(`FAULT_DELAY_CYCLES - 1);
  localparam logic [7:0]  DEACT_LAST = 8'(`DEACT_CYCLES - 1);

  sc_port_pkg::dev_core_t  c;
  sc_port_pkg::dev_core_t  next_c;
  sc_port_pkg::dev_shift_t s;
  sc_port_pkg::dev_shift_t next_s;
  sc_port_pkg::dev_out_t   o;
  sc_port_pkg::dev_out_t   next_o;

  logic [7:0] status;
  logic       want_on;
  logic       removal;
  logic       fault_cond;
  logic       fault_set;
  logic       fault_clr;

  // status byte as returned to the host
  always_comb begin
    status = 8'h00;
    status[`CARD_PRESENT_POS] = c.present;
    status[`ACTIVE_POS] = (c.state != sc_port_pkg::DEV_OFF);
    status[`FAULT_POS] = c.fault;
    status[`PWR_BIT1_POS] = c.cmd[`PWR_BIT1_POS];
    status[`PWR_BIT0_POS] = c.cmd[`PWR_BIT0_POS];
  end

  // core on clk
  always_comb begin
    next_c = c;
    want_on = 1'b0;
    removal = 1'b0;
    fault_cond = 1'b0;
    fault_set = 1'b0;
    fault_clr = 1'b0;
    next_c.ld_s1 = link.load_strobe_n;
    next_c.ld_s2 = c.ld_s1;
    next_c.ld_d = c.ld_s2;
    next_c.det_s1 = card_detect_in;
    next_c.det_s2 = c.det_s1;
    next_c.uv_s1 = supply_undervolt_sense;
    next_c.uv_s2 = c.uv_s1;
    next_c.sup_s1 = logic_supply;
    next_c.sup_s2 = c.sup_s1;

    // card detect input is high with no card
    if (c.det_s2) begin
      next_c.deb_cnt = 20'h00000;
      next_c.present = 1'b0;
    end else if (!c.present) begin
      if (c.deb_cnt == DEB_LAST) begin
        next_c.present = 1'b1;
      end else begin
        next_c.deb_cnt = c.deb_cnt + 20'h00001;
      end
    end

    // the shifter is idle between frames, so its word is static here
    if (c.ld_d && !c.ld_s2) begin
      next_c.cmd = s.shreg;
      fault_clr = (s.shreg[`PWR_BIT1_POS:`PWR_BIT0_POS] == 2'b00);
    end
    if (!c.ld_d && c.ld_s2) begin
      next_c.snap = status;
      next_c.snap_tgl = ~c.snap_tgl;
    end

    // next_c.cmd is used so the new command acts in the load cycle
    want_on = |next_c.cmd[`PWR_BIT1_POS:`PWR_BIT0_POS];

    removal = (c.state == sc_port_pkg::DEV_ON) && c.det_s2;
    fault_cond = ((c.state == sc_port_pkg::DEV_ON) && c.uv_s2) ||
                 ((c.state == sc_port_pkg::DEV_OFF) && want_on && !c.present && !c.fault);

    // faults other than card removal must persist through the delay window to count
    if (removal) begin
      fault_set = 1'b1;
      next_c.flt_pend = 1'b0;
    end else if (!fault_cond) begin
      next_c.flt_pend = 1'b0;
      next_c.flt_cnt = 10'h000;
    end else if (!c.flt_pend) begin
      next_c.flt_pend = 1'b1;
      next_c.flt_cnt = 10'h000;
    end else if (c.flt_cnt == FLT_LAST) begin
      fault_set = 1'b1;
      next_c.flt_pend = 1'b0;
    end else begin
      next_c.flt_cnt = c.flt_cnt + 10'h001;
    end

    // set wins over the clear of a deactivate command
    if (fault_set) begin
      next_c.fault = 1'b1;
    end else if (fault_clr) begin
      next_c.fault = 1'b0;
    end

    case (c.state)
      sc_port_pkg::DEV_OFF: begin
        if (want_on && c.present && !c.fault && !fault_set) begin
          next_c.state = sc_port_pkg::DEV_ON;
        end
      end
      sc_port_pkg::DEV_ON: begin
        if (!want_on || fault_set) begin
          next_c.state = sc_port_pkg::DEV_DEACT;
          next_c.seq_cnt = 8'h00;
        end
      end
      sc_port_pkg::DEV_DEACT: begin
        if (c.seq_cnt == DEACT_LAST) begin
          next_c.state = sc_port_pkg::DEV_OFF;
        end else begin
          next_c.seq_cnt = c.seq_cnt + 8'h01;
        end
      end
      default: begin
        next_c.state = sc_port_pkg::DEV_OFF;
      end
    endcase

    // grounded logic supply drops the card without sequencing
    if (!c.sup_s2) begin
      next_c.cmd = `CMD_RESET;
      next_c.state = sc_port_pkg::DEV_OFF;
      next_c.flt_pend = 1'b0;
    end

    if (!nrst) begin
      next_c = '0;
      next_c.ld_s1 = 1'b0;
      next_c.ld_s2 = 1'b0;
      next_c.ld_d = 1'b0;
      next_c.det_s1 = 1'b1;
      next_c.det_s2 = 1'b1;
      next_c.sup_s1 = 1'b1;
      next_c.sup_s2 = 1'b1;
      next_c.cmd = `CMD_RESET;
      next_c.state = sc_port_pkg::DEV_OFF;
    end
  end

  always_ff @(posedge clk) begin
    c <= next_c;
  end

  // link side, rising edge: sample serial in
  // snap is held static from capture to the next strobe fall, and the
  // host waits a setup gap before its first edge, so reading it here is safe
  always_comb begin
    next_s = s;
    next_s.used_tgl = c.snap_tgl;
    if (s.used_tgl != c.snap_tgl) begin
      next_s.shreg = {c.snap[6:0], link.din};
    end else begin
      next_s.shreg = {s.shreg[6:0], link.din};
    end
    if (!nrst) begin
      next_s = '0;
    end
  end

  always_ff @(posedge link.sclk) begin
    s <= next_s;
  end

  // link side, falling edge: move serial out
  always_comb begin
    next_o = o;
    next_o.out_bit = s.shreg[7];
    next_o.seen_tgl = s.used_tgl;
    if (!nrst) begin
      next_o = '0;
    end
  end

  always_ff @(negedge link.sclk) begin
    o <= next_o;
  end

  // strobe low makes the port a live card detect line
  always_comb begin
    if (!c.ld_s2) begin
      link.dout = c.present;
    end else if (o.seen_tgl != c.snap_tgl) begin
      link.dout = c.snap[7];
    end else begin
      link.dout = o.out_bit;
    end
  end

  // open drain: sink the line while faulted
  assign link.fault_o = 1'b0;
  assign link.fault_oe_n = ~c.fault;

  assign card_vcc_en = (c.state != sc_port_pkg::DEV_OFF);
  assign card_rst_en = (c.state == sc_port_pkg::DEV_ON);
  assign vcc_sel = c.cmd[`PWR_BIT1_POS:`PWR_BIT0_POS];
  assign command = c.cmd;
  assign shutdown = ~c.sup_s2;
  assign deact_busy = (c.state == sc_port_pkg::DEV_DEACT);
endmodule

// >>> sc_port_host.sv
// host end: apb registers and serial master that makes the link clock
`timescale 1ns/100ps
`include "sc_port_defs.svh"
module sc_port_host #(
  parameter int unsigned CHAIN_BYTES = `CHAIN_BYTES,
  parameter int unsigned SCLK_HALF   = `SCLK_HALF,
  parameter int unsigned LD_SETUP    = `LD_SETUP
) (
  // system
  input  wire logic        clk,
  input  wire logic        nrst,
  // apb
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // link
  sc_link_if.host          link
);
  localparam logic [5:0] TOT_BITS  = 6'(`FRAME_BITS * CHAIN_BYTES);
  localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF - 1);
  localparam logic [7:0] SETUP_LAST = 8'(LD_SETUP - 1);

  sc_port_pkg::host_t h;
  sc_port_pkg::host_t next_h;
  logic               wr;
  logic               setup;
  logic               busy;

  assign wr = psel && penable && pwrite;
  assign setup = psel && !penable;
  assign busy = (h.st != sc_port_pkg::H_IDLE);

  always_comb begin
    next_h = h;
    next_h.dout_s1 = link.dout;
    next_h.dout_s2 = h.dout_s1;
    next_h.flt_s1 = link.fault_line;
    next_h.flt_s2 = h.flt_s1;

    // register read data is fetched in the setup cycle
    if (setup) begin
      next_h.pslverr = 1'b0;
      next_h.prdata = 32'h00000000;
      if (paddr == `REG_CTRL) begin
        next_h.prdata = 32'h00000000;
      end else if (paddr == `REG_TXDATA) begin
        next_h.prdata = h.txreg;
      end else if (paddr == `REG_RXDATA) begin
        next_h.prdata = h.rx;
      end else if (paddr == `REG_STATUS) begin
        next_h.prdata[`STAT_BUSY_POS] = busy;
        next_h.prdata[`STAT_FAULT_POS] = ~h.flt_s2;
        next_h.prdata[`STAT_CARD_POS] = h.dout_s2 && !busy;
      end else begin
        next_h.pslverr = 1'b1;
      end
    end
    if (wr && paddr == `REG_TXDATA) begin
      next_h.txreg = pwdata;
    end

    case (h.st)
      sc_port_pkg::H_IDLE: begin
        next_h.sclk = 1'b1;
        next_h.ld_n = 1'b0;
        if (wr && paddr == `REG_CTRL && pwdata[`CTRL_START_POS]) begin
          next_h.ld_n = 1'b1;
          next_h.sh = h.txreg << (6'd32 - TOT_BITS);
          next_h.cnt = 8'h00;
          next_h.bits = 6'h00;
          next_h.st = sc_port_pkg::H_SETUP;
        end
      end
      sc_port_pkg::H_SETUP: begin
        if (h.cnt == SETUP_LAST) begin
          next_h.sclk = 1'b0;
          next_h.din = h.sh[31];
          next_h.sh = {h.sh[30:0], 1'b0};
          next_h.cnt = 8'h00;
          next_h.st = sc_port_pkg::H_SHIFT;
        end else begin
          next_h.cnt = h.cnt + 8'h01;
        end
      end
      sc_port_pkg::H_SHIFT: begin
        if (h.cnt != HALF_LAST) begin
          next_h.cnt = h.cnt + 8'h01;
        end else if (!h.sclk) begin
          next_h.sclk = 1'b1;
          next_h.bits = h.bits + 6'h01;
          next_h.cnt = 8'h00;
        end else if (h.bits == TOT_BITS) begin
          // synchroniser lag: each bit is taken one fall late, the last one here
          next_h.rx = {h.rx[30:0], h.dout_s2};
          next_h.ld_n = 1'b0;
          next_h.st = sc_port_pkg::H_IDLE;
        end else begin
          next_h.sclk = 1'b0;
          next_h.din = h.sh[31];
          next_h.sh = {h.sh[30:0], 1'b0};
          next_h.rx = {h.rx[30:0], h.dout_s2};
          next_h.cnt = 8'h00;
        end
      end
      default: begin
        next_h.st = sc_port_pkg::H_IDLE;
      end
    endcase

    // link clock runs during reset so the device shifter resets too
    if (!nrst) begin
      next_h = '0;
      next_h.st = sc_port_pkg::H_IDLE;
      // if-form so an unset start level still begins to toggle
      if (h.sclk) begin
        next_h.sclk = 1'b0;
      end else begin
        next_h.sclk = 1'b1;
      end
      next_h.flt_s1 = 1'b1;
      next_h.flt_s2 = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    h <= next_h;
  end

  assign prdata = h.prdata;
  assign pready = 1'b1;
  assign pslverr = h.pslverr && psel && penable;
  assign link.sclk = h.sclk;
  assign link.din = h.din;
  assign link.load_strobe_n = h.ld_n;
endmodule

// >>> sc_link_monitor.sv
// assertions on the serial link between the host and device ends
`timescale 1ns/100ps
module sc_link_monitor (
  // system
  input wire logic clk,
  input wire logic nrst,
  // link
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic load_strobe_n,
  input wire logic fault_o,
  input wire logic fault_oe_n
);
  logic       sclk_q;
  logic [5:0] rises;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // host makes sclk from clk, so rises are counted on clk
  always_ff @(posedge clk) begin
    sclk_q <= sclk;
    if (!nrst || !load_strobe_n) begin
      rises <= 6'h00;
    end else if (sclk && !sclk_q) begin
      rises <= rises + 6'h01;
    end
  end

  sequence low_half;   !sclk [*2] ##1 sclk; endsequence
  sequence high_half;  sclk [*2] ##1 !sclk; endsequence
  sequence setup_wait; sclk [*4] ##1 !sclk; endsequence
  sequence strobe_end; load_strobe_n [*2] ##1 !load_strobe_n; endsequence

  chk_idle_high: assert property (($past(nrst) && !load_strobe_n) |-> sclk)
    else $error("sclk not high while idle");
  chk_setup_gap: assert property ($rose(load_strobe_n) |-> setup_wait)
    else $error("first sclk fall not after setup gap");
  chk_low_half: assert property (($past(nrst) && load_strobe_n && $fell(sclk)) |-> low_half)
    else $error("sclk low half wrong");
  chk_high_half: assert property
    ((load_strobe_n && $rose(sclk) && rises < 6'h07) |-> high_half)
    else $error("sclk high half wrong");
  chk_strobe_end: assert property
    ((load_strobe_n && $rose(sclk) && rises == 6'h07) |-> strobe_end)
    else $error("strobe not dropped after last bit");
  chk_bit_count: assert property ($fell(load_strobe_n) |-> rises == 6'h08)
    else $error("frame bit count wrong");
  chk_din_edge: assert property
    ((load_strobe_n && $past(load_strobe_n) && $changed(din)) |-> $fell(sclk))
    else $error("din moved off a falling edge");
  chk_dout_edge: assert property
    ((load_strobe_n && $past(load_strobe_n) && rises != 6'h00 && $changed(dout)) |-> $fell(sclk))
    else $error("dout moved off a falling edge");
  chk_fault_sink: assert property (!fault_oe_n |-> !fault_o)
    else $error("fault line driven high");
endmodule

// >>> tb_top.sv
// testbench joining host and device ends over the serial link
`timescale 1ns/100ps
`include "sc_port_defs.svh"
module tb_top;
  logic        clk = 1'b0;
  logic        nrst;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        card_detect_in;
  logic        supply_undervolt_sense;
  logic        logic_supply;
  logic        card_vcc_en;
  logic        card_rst_en;
  logic [1:0]  vcc_sel;
  logic [7:0]  command;
  logic        shutdown;
  logic        deact_busy;
  logic [31:0] rd;
  logic        er;
  int          n_errors;
  int          tests_run;

  sc_link_if link ();

  sc_port_host u_sc_port_host (
    .clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link)
  );

  // short debounce keeps the run brief
  sc_port_dev #(.DEBOUNCE_CYCLES(16)) u_sc_port_dev (
    .clk(clk), .nrst(nrst), .link(link), .card_detect_in(card_detect_in),
    .supply_undervolt_sense(supply_undervolt_sense), .logic_supply(logic_supply),
    .card_vcc_en(card_vcc_en), .card_rst_en(card_rst_en), .vcc_sel(vcc_sel),
    .command(command), .shutdown(shutdown), .deact_busy(deact_busy)
  );

  sc_link_monitor u_sc_link_monitor (
    .clk(clk), .nrst(nrst), .sclk(link.sclk), .din(link.din), .dout(link.dout),
    .load_strobe_n(link.load_strobe_n), .fault_o(link.fault_o),
    .fault_oe_n(link.fault_oe_n)
  );

  always #20 clk = ~clk;

  task automatic summarize();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one apb transfer; idles a cycle after so the next setup is a fresh edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (pready !== 1'b1) begin
      n_errors++;
      summarize();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // send one byte, wait for busy to clear, let the device see the strobe
  task automatic frame(input logic [7:0] b);
    int i;
    apb(1'b1, `REG_TXDATA, {24'h000000, b}, rd, er);
    apb(1'b1, `REG_CTRL, 32'h00000001, rd, er);
    i = 0;
    do begin
      apb(1'b0, `REG_STATUS, 32'h00000000, rd, er);
      i++;
    end while (rd[`STAT_BUSY_POS] !== 1'b0 && i < 100);
    if (rd[`STAT_BUSY_POS] !== 1'b0) begin
      n_errors++;
      summarize();
    end
    repeat (4) @(posedge clk);
  endtask

  initial begin
    nrst = 1'b0;
    paddr = 12'h000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h00000000;
    card_detect_in = 1'b1;
    supply_undervolt_sense = 1'b0;
    logic_supply = 1'b1;
    n_errors = 0;
    tests_run = 0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    apb(1'b0, `REG_STATUS, 32'h00000000, rd, er);
    chk(rd, 32'h00000000);
    apb(1'b0, 12'h010, 32'h00000000, rd, er);
    chk({rd[30:0], er}, 32'h00000001);
    $display("done registers");
    card_detect_in <= 1'b0;
    repeat (8) @(posedge clk);
    chk(link.dout, 32'h0);
    repeat (20) @(posedge clk);
    chk(link.dout, 32'h1);
    apb(1'b0, `REG_STATUS, 32'h00000000, rd, er);
    chk(rd[`STAT_CARD_POS], 32'h1);
    $display("done card detect");
    frame(8'h03);
    chk(command, 32'h03);
    chk({card_vcc_en, card_rst_en, vcc_sel}, 32'hF);
    frame(8'h00);
    apb(1'b0, `REG_RXDATA, 32'h00000000, rd, er);
    chk(rd[7:0], 32'hC3);
    chk({deact_busy, card_rst_en}, 32'h2);
    repeat (`DEACT_CYCLES) @(posedge clk);
    chk(card_vcc_en, 32'h0);
    frame(8'h00);
    apb(1'b0, `REG_RXDATA, 32'h00000000, rd, er);
    chk(rd[7:0], 32'h80);
    chk(link.dout, 32'h1);
    $display("done frames");
    // undervolt must persist through the filter before it trips
    frame(8'h01);
    supply_undervolt_sense <= 1'b1;
    repeat (`FAULT_DELAY_CYCLES - 50) @(posedge clk);
    chk(link.fault_line, 32'h1);
    repeat (100) @(posedge clk);
    chk({link.fault_line, card_rst_en}, 32'h0);
    apb(1'b0, `REG_STATUS, 32'h00000000, rd, er);
    chk(rd[`STAT_FAULT_POS], 32'h1);
    supply_undervolt_sense <= 1'b0;
    frame(8'h00);
    apb(1'b0, `REG_RXDATA, 32'h00000000, rd, er);
    chk(rd[`FAULT_POS], 32'h1);
    chk(link.fault_line, 32'h1);
    $display("done fault");
    frame(8'h02);
    chk(card_vcc_en, 32'h1);
    logic_supply <= 1'b0;
    repeat (4) @(posedge clk);
    chk({shutdown, card_vcc_en, command}, 32'h200);
    logic_supply <= 1'b1;
    $display("done shutdown");
    summarize();
  end
endmodule
